/* hw/hlf_pkg.sv */
package hlf_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_HZ         = 200_000_000;
  localparam int BAUD_4800      = 4800;
  localparam int BAUD_9600      = 9600;
  localparam int BAUD_19200     = 19200;
  localparam int DIV_4800       = CLK_HZ / BAUD_4800;
  localparam int DIV_9600       = CLK_HZ / BAUD_9600;
  localparam int DIV_19200      = CLK_HZ / BAUD_19200;
  localparam int DIV_W          = 17;
  localparam int I2C_RATE_BPS   = 100_000;
  localparam int CFG_LIMIT_US   = 200;
  localparam int CFG_SETTLE_NS  = 1000;
  localparam int CFG_SETTLE_CYC = (CFG_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int STRAP_WAIT_CYC = 3;
  // ==========================================
  // character framing and command syntax
  localparam int        DATA_BITS  = 8;
  localparam logic [7:0] CH_SLASH  = 8'h2f;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_ALL    = 8'h30;
  localparam logic [7:0] ADDR_MIN  = 8'h41;
  localparam logic [7:0] ADDR_MAX  = 8'h5a;
  localparam logic [7:0] ADDR_RST  = 8'h41;
  localparam logic [7:0] I2C_IDLE_BYTE = 8'hff;
  // ==========================================
  // reset values and encodings
  localparam logic [1:0] BAUD_CODE_4800  = 2'h0;
  localparam logic [1:0] BAUD_CODE_9600  = 2'h1;
  localparam logic [1:0] BAUD_CODE_19200 = 2'h2;
  localparam logic [1:0] BAUD_RST        = BAUD_CODE_9600;
  localparam logic [2:0] CFG_MIN = 3'h1;
  localparam logic [2:0] CFG_MAX = 3'h6;
  localparam logic [2:0] CFG_RST = 3'h1;
  typedef enum logic [2:0] {
    LINK_I2C = 3'b001,
    LINK_SER = 3'b010,
    LINK_INV = 3'b100
  } hlf_link_e;
endpackage

/* hw/hlf_host_link_frontend.sv */
// Operation
// - link type chosen from two select straps
// - both open I2C, A low serial, B low inverted
// - select pins pulled up, open reads high
// - I2C slave mode at 100 kbps
// - baud 4800/9600/19200, 9600 after reset
// - frames are 8N1 both ways
// - no flow control on serial link
// - data pin is TX, clock pin RX
// - clear pin active high, pulled down
// - inverted serial flips both line polarities
// - six configurations, switchable at run time
// - configuration switch done within 200 us
// - command is slash, address, code, params, CR
// - answer own address or 0x30 (all), default 0x41
module hlf_host_link_frontend
  import hlf_pkg::*;
#(
  parameter int         DIV4800  = DIV_4800,
  parameter int         DIV9600  = DIV_9600,
  parameter int         DIV19200 = DIV_19200,
  parameter logic [6:0] I2C_ADDR = 7'h50
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_external_clear_pin,
  // straps
  input  wire logic       i_link_select_a,
  input  wire logic       i_link_select_b,
  // shared host pins
  input  wire logic       i_scl_rx,
  input  wire logic       i_sda_tx,
  output logic            o_sda_tx,
  output logic            o_sda_oe,
  // control from the command interpreter
  input  wire logic       i_baud_load,
  input  wire logic [1:0] i_baud_code,
  input  wire logic       i_addr_load,
  input  wire logic [7:0] i_addr,
  input  wire logic       i_cfg_req,
  input  wire logic [2:0] i_cfg_num,
  // reply bytes
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  // status
  output logic [2:0]      o_link,
  output logic            o_link_valid,
  output logic [1:0]      o_baud_code,
  output logic [7:0]      o_dev_addr,
  output logic [2:0]      o_cfg,
  output logic            o_cfg_busy,
  // decoded command stream
  output logic            o_cmd_start,
  output logic [7:0]      o_cmd_code,
  output logic            o_param_valid,
  output logic [7:0]      o_param_data,
  output logic            o_cmd_done
);
  // ==========================================
  // pin synchronisers
  // pad pull-ups on the straps and pull-down on the clear pin sit outside; open pins arrive as 1 / 0
  logic [4:0] s1;
  logic [4:0] s2;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      // clear pin rests low, straps and bus lines rest high: no false clear after reset
      s1 <= 5'h0f;
      s2 <= 5'h0f;
    end else begin
      s1 <= {i_external_clear_pin, i_link_select_a, i_link_select_b, i_scl_rx, i_sda_tx};
      s2 <= s1;
    end
  end
  logic clr;
  logic sel_a;
  logic sel_b;
  logic scl;
  logic sda;
  assign clr   = s2[4];
  assign sel_a = s2[3];
  assign sel_b = s2[2];
  assign scl   = s2[1];
  assign sda   = s2[0];

  // ==========================================
  // link choice, baud, address, configuration
  hlf_link_e  link;
  hlf_link_e  next_link;
  logic       lvalid;
  logic       next_lvalid;
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic [1:0] baud;
  logic [1:0] next_baud;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic [2:0] cfg;
  logic [2:0] next_cfg;
  logic [2:0] cfg_pend;
  logic [2:0] next_cfg_pend;
  logic [7:0] cfg_cnt;
  logic [7:0] next_cfg_cnt;
  always_comb begin
    next_link     = link;
    next_lvalid   = lvalid;
    next_wait_cnt = wait_cnt;
    next_baud     = baud;
    next_addr     = addr;
    next_cfg      = cfg;
    next_cfg_pend = cfg_pend;
    next_cfg_cnt  = cfg_cnt;
    if (clr) begin
      next_lvalid   = 1'b0;
      next_wait_cnt = 2'h0;
      next_baud     = BAUD_RST;
    end else if (!lvalid) begin
      // wait out the synchroniser before trusting the strap levels
      if (wait_cnt == 2'(STRAP_WAIT_CYC - 1)) begin
        next_lvalid = 1'b1;
        if (!sel_a && sel_b)      next_link = LINK_SER;
        else if (sel_a && !sel_b) next_link = LINK_INV;
        else                      next_link = LINK_I2C;
      end else begin
        next_wait_cnt = wait_cnt + 2'h1;
      end
    end
    if (!clr && i_baud_load && i_baud_code <= BAUD_CODE_19200) next_baud = i_baud_code;
    if (i_addr_load && i_addr >= ADDR_MIN && i_addr <= ADDR_MAX) next_addr = i_addr;
    if (cfg_cnt != 8'h0) begin
      next_cfg_cnt = cfg_cnt - 8'h1;
      if (cfg_cnt == 8'h1) next_cfg = cfg_pend;
    end else if (i_cfg_req && i_cfg_num >= CFG_MIN && i_cfg_num <= CFG_MAX) begin
      next_cfg_pend = i_cfg_num;
      next_cfg_cnt  = 8'(CFG_SETTLE_CYC);
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      link     <= LINK_I2C;
      lvalid   <= 1'b0;
      wait_cnt <= 2'h0;
      baud     <= BAUD_RST;
      addr     <= ADDR_RST;
      cfg      <= CFG_RST;
      cfg_pend <= CFG_RST;
      cfg_cnt  <= 8'h0;
    end else begin
      link     <= next_link;
      lvalid   <= next_lvalid;
      wait_cnt <= next_wait_cnt;
      baud     <= next_baud;
      addr     <= next_addr;
      cfg      <= next_cfg;
      cfg_pend <= next_cfg_pend;
      cfg_cnt  <= next_cfg_cnt;
    end
  end

  logic           ser_on;
  logic           inv;
  logic [DIV_W-1:0] div;
  assign ser_on = lvalid && !clr && (link != LINK_I2C);
  assign inv    = (link == LINK_INV);
  always_comb begin
    case (baud)
      BAUD_CODE_4800:  div = DIV_W'(DIV4800);
      BAUD_CODE_19200: div = DIV_W'(DIV19200);
      default:         div = DIV_W'(DIV9600);
    endcase
  end

  // ==========================================
  // serial receiver, 8N1, on the clock pin
  typedef enum logic [3:0] {R_IDLE = 4'b0001, R_START = 4'b0010, R_DATA = 4'b0100, R_STOP = 4'b1000} hlf_rx_e;
  hlf_rx_e          rx_st;
  hlf_rx_e          next_rx_st;
  logic [DIV_W-1:0] rx_tm;
  logic [DIV_W-1:0] next_rx_tm;
  logic [2:0]       rx_n;
  logic [2:0]       next_rx_n;
  logic [7:0]       rx_sh;
  logic [7:0]       next_rx_sh;
  logic             rx_line;
  logic             u_valid;
  assign rx_line = scl ^ inv;
  always_comb begin
    next_rx_st = rx_st;
    next_rx_tm = rx_tm;
    next_rx_n  = rx_n;
    next_rx_sh = rx_sh;
    u_valid    = 1'b0;
    if (!ser_on) begin
      next_rx_st = R_IDLE;
    end else if (rx_tm != '0) begin
      next_rx_tm = rx_tm - 1'b1;
    end else begin
      case (rx_st)
        R_IDLE: if (!rx_line) begin
          next_rx_st = R_START;
          next_rx_tm = div >> 1;
        end
        R_START: if (!rx_line) begin
          next_rx_st = R_DATA;
          next_rx_n  = 3'h0;
          next_rx_tm = div - 1'b1;
        end else begin
          next_rx_st = R_IDLE;
        end
        R_DATA: begin
          next_rx_sh = {rx_line, rx_sh[7:1]};
          next_rx_tm = div - 1'b1;
          next_rx_n  = rx_n + 3'h1;
          if (rx_n == 3'(DATA_BITS - 1)) next_rx_st = R_STOP;
        end
        R_STOP: begin
          // a bad stop bit drops the character; no parity to check
          u_valid    = rx_line;
          next_rx_st = R_IDLE;
        end
        default: next_rx_st = R_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rx_st <= R_IDLE;
      rx_tm <= '0;
      rx_n  <= 3'h0;
      rx_sh <= 8'h0;
    end else begin
      rx_st <= next_rx_st;
      rx_tm <= next_rx_tm;
      rx_n  <= next_rx_n;
      rx_sh <= next_rx_sh;
    end
  end

  // ==========================================
  // serial transmitter; no flow control, so ready only follows the shifter
  typedef enum logic [2:0] {T_IDLE = 3'b001, T_DATA = 3'b010, T_STOP = 3'b100} hlf_tx_e;
  hlf_tx_e          tx_st;
  hlf_tx_e          next_tx_st;
  logic [DIV_W-1:0] tx_tm;
  logic [DIV_W-1:0] next_tx_tm;
  logic [3:0]       tx_n;
  logic [3:0]       next_tx_n;
  logic [8:0]       tx_sh;
  logic [8:0]       next_tx_sh;
  logic             i2c_take;
  always_comb begin
    next_tx_st = tx_st;
    next_tx_tm = tx_tm;
    next_tx_n  = tx_n;
    next_tx_sh = tx_sh;
    if (!ser_on) begin
      next_tx_st = T_IDLE;
      next_tx_sh = 9'h1ff;
    end else if (tx_st == T_IDLE) begin
      if (i_tx_valid) begin
        next_tx_st = T_DATA;
        next_tx_sh = {i_tx_data, 1'b0};
        next_tx_n  = 4'h0;
        next_tx_tm = div - 1'b1;
      end
    end else if (tx_tm != '0) begin
      next_tx_tm = tx_tm - 1'b1;
    end else begin
      case (tx_st)
        T_DATA: begin
          next_tx_sh = {1'b1, tx_sh[8:1]};
          next_tx_n  = tx_n + 4'h1;
          next_tx_tm = div - 1'b1;
          if (tx_n == 4'(DATA_BITS)) next_tx_st = T_STOP;
        end
        T_STOP:  next_tx_st = T_IDLE;
        default: next_tx_st = T_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tx_st <= T_IDLE;
      tx_tm <= '0;
      tx_n  <= 4'h0;
      tx_sh <= 9'h1ff;
    end else begin
      tx_st <= next_tx_st;
      tx_tm <= next_tx_tm;
      tx_n  <= next_tx_n;
      tx_sh <= next_tx_sh;
    end
  end
  assign o_tx_ready = ser_on ? (tx_st == T_IDLE) : i2c_take;

  // ==========================================
  // I2C slave; 200 MHz oversampling easily resolves 100 kbps edges
  typedef enum logic [5:0] {
    I_IDLE = 6'b000001, I_ADDR = 6'b000010, I_ACKA = 6'b000100,
    I_WR   = 6'b001000, I_RD   = 6'b010000, I_RACK = 6'b100000
  } hlf_i2c_e;
  hlf_i2c_e   ist;
  hlf_i2c_e   next_ist;
  logic [7:0] ish;
  logic [7:0] next_ish;
  logic [3:0] in;
  logic [3:0] next_in;
  logic       irw;
  logic       next_irw;
  logic       iack;
  logic       next_iack;
  logic       idrv;
  logic       next_idrv;
  logic       scl_d;
  logic       sda_d;
  logic       i_valid;
  logic       i2c_on;
  logic       srise;
  logic       sfall;
  assign i2c_on = lvalid && !clr && (link == LINK_I2C);
  assign srise  = scl && !scl_d;
  assign sfall  = !scl && scl_d;
  always_comb begin
    next_ist  = ist;
    next_ish  = ish;
    next_in   = in;
    next_irw  = irw;
    next_iack = iack;
    next_idrv = idrv;
    i_valid   = 1'b0;
    i2c_take  = 1'b0;
    if (!i2c_on || (scl && scl_d && sda && !sda_d)) begin // stop
      next_ist  = I_IDLE;
      next_idrv = 1'b0;
    end else if (scl && scl_d && !sda && sda_d) begin    // start or repeated start
      next_ist  = I_ADDR;
      next_in   = 4'h0;
      next_idrv = 1'b0;
    end else begin
      case (ist)
        I_IDLE: next_idrv = 1'b0;
        I_ADDR, I_WR: begin
          if (srise && in < 4'h8) begin
            next_ish = {ish[6:0], sda};
            next_in  = in + 4'h1;
          end
          if (sfall && in == 4'h8) begin
            next_in = 4'h0;
            if (ist == I_WR) begin
              i_valid   = 1'b1;
              next_idrv = 1'b1;
              // count 9 marks the ack clock, so its rising edge is not taken as data
              next_in   = 4'h9;
            end else if (ish[7:1] == I2C_ADDR) begin
              next_irw  = ish[0];
              next_idrv = 1'b1;
              next_ist  = I_ACKA;
            end else begin
              next_ist = I_IDLE;
            end
          end else if (sfall && in == 4'h9) begin
            next_idrv = 1'b0;                         // release after the ack clock
            next_in   = 4'h0;
          end
        end
        I_ACKA: if (sfall) begin
          next_in = 4'h0;
          if (irw) begin
            i2c_take  = 1'b1;
            next_ish  = i_tx_valid ? i_tx_data : I2C_IDLE_BYTE;
            next_idrv = i_tx_valid ? !i_tx_data[7] : 1'b0;
            next_ist  = I_RD;
          end else begin
            next_idrv = 1'b0;
            next_ist  = I_WR;
          end
        end
        I_RD: begin
          if (srise) next_in = in + 4'h1;
          if (sfall) begin
            if (in == 4'h8) begin
              next_idrv = 1'b0;
              next_ist  = I_RACK;
            end else begin
              next_ish  = {ish[6:0], 1'b1};
              next_idrv = !ish[6];
            end
          end
        end
        I_RACK: begin
          if (srise) next_iack = !sda;
          if (sfall) begin
            // master acked: the next byte must be on the line from this very fall
            next_in   = 4'h0;
            i2c_take  = iack;
            next_ish  = (iack && i_tx_valid) ? i_tx_data : I2C_IDLE_BYTE;
            next_idrv = iack && i_tx_valid && !i_tx_data[7];
            next_ist  = iack ? I_RD : I_IDLE;
          end
        end
        default: next_ist = I_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ist   <= I_IDLE;
      ish   <= 8'h0;
      in    <= 4'h0;
      irw   <= 1'b0;
      iack  <= 1'b0;
      idrv  <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      ist   <= next_ist;
      ish   <= next_ish;
      in    <= next_in;
      irw   <= next_irw;
      iack  <= next_iack;
      idrv  <= next_idrv;
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // data pin: push-pull TX in serial modes, open-drain in I2C
  always_comb begin
    o_sda_tx = 1'b0;
    o_sda_oe = 1'b0;
    if (ser_on) begin
      o_sda_tx = tx_sh[0] ^ inv;
      o_sda_oe = 1'b1;
    end else if (i2c_on) begin
      o_sda_oe = idrv;
    end
  end

  // ==========================================
  // command framer
  typedef enum logic [3:0] {P_IDLE = 4'b0001, P_ADDR = 4'b0010, P_CMD = 4'b0100, P_PAR = 4'b1000} hlf_par_e;
  hlf_par_e   pst;
  hlf_par_e   next_pst;
  logic       pmine;
  logic       next_pmine;
  logic [7:0] code;
  logic [7:0] next_code;
  logic [7:0] pdat;
  logic [7:0] next_pdat;
  logic [2:0] pulse;
  logic [2:0] next_pulse;
  logic       bv;
  logic [7:0] b;
  assign bv = u_valid || i_valid;
  assign b  = u_valid ? rx_sh : ish;
  always_comb begin
    next_pst   = pst;
    next_pmine = pmine;
    next_code  = code;
    next_pdat  = pdat;
    next_pulse = 3'h0;
    if (bv) begin
      if (b == CH_SLASH) begin
        next_pst = P_ADDR;
      end else begin
        case (pst)
          P_ADDR: begin
            next_pmine = (b == addr) || (b == CH_ALL);
            next_pst   = P_CMD;
          end
          P_CMD: begin
            next_pst = (b == CH_CR) ? P_IDLE : P_PAR;
            if (pmine && b != CH_CR) begin
              next_code     = b;
              next_pulse[0] = 1'b1;
            end
          end
          P_PAR: if (b == CH_CR) begin
            next_pst      = P_IDLE;
            next_pulse[2] = pmine;
          end else if (pmine) begin
            next_pdat     = b;
            next_pulse[1] = 1'b1;
          end
          P_IDLE:  next_pst = P_IDLE;
          default: next_pst = P_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pst   <= P_IDLE;
      pmine <= 1'b0;
      code  <= 8'h0;
      pdat  <= 8'h0;
      pulse <= 3'h0;
    end else begin
      pst   <= next_pst;
      pmine <= next_pmine;
      code  <= next_code;
      pdat  <= next_pdat;
      pulse <= next_pulse;
    end
  end

  assign o_link        = link;
  assign o_link_valid  = lvalid;
  assign o_baud_code   = baud;
  assign o_dev_addr    = addr;
  assign o_cfg         = cfg;
  assign o_cfg_busy    = (cfg_cnt != 8'h0);
  assign o_cmd_start   = pulse[0];
  assign o_cmd_code    = code;
  assign o_param_valid = pulse[1];
  assign o_param_data  = pdat;
  assign o_cmd_done    = pulse[2];
endmodule

/* tb/hlf_chk.sv */
module hlf_chk
  import hlf_pkg::*;
(
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_external_clear_pin,
  // pin drive
  input wire logic       o_sda_tx,
  input wire logic       o_sda_oe,
  input wire logic       o_tx_ready,
  // status
  input wire logic [2:0] o_link,
  input wire logic       o_link_valid,
  input wire logic [1:0] o_baud_code,
  input wire logic [7:0] o_dev_addr,
  input wire logic [2:0] o_cfg,
  input wire logic       o_cfg_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // ==========================================
  // link choice
  a_link_one_hot: assert property (o_link_valid |-> o_link inside {LINK_I2C, LINK_SER, LINK_INV})
    else $error("link code is not a single link");
  a_strap_hold: assert property (o_link_valid && $past(o_link_valid) |-> $stable(o_link))
    else $error("link changed while latched");
  a_clear_drop: assert property (i_external_clear_pin [*5] |-> !o_link_valid && o_baud_code == BAUD_RST)
    else $error("clear pin did not drop the link");
  a_baud_fresh: assert property ($rose(o_link_valid) |-> o_baud_code == BAUD_RST)
    else $error("link came up without default rate");

  // ==========================================
  // shared pin use
  // the synchronised clear releases the pin one cycle before the link drops
  a_serial_drive: assert property (o_link_valid && o_link != LINK_I2C && !$past(i_external_clear_pin, 2) |-> o_sda_oe)
    else $error("serial transmit pin not driven");
  a_i2c_open_drain: assert property (o_link == LINK_I2C && o_sda_oe |-> !o_sda_tx)
    else $error("bus data line driven high");
  // idle level tells the two serial polarities apart
  a_tx_idle_level: assert property (o_link_valid && o_link != LINK_I2C && o_tx_ready |->
                                    o_sda_tx == (o_link == LINK_SER))
    else $error("serial idle level wrong");

  // ==========================================
  // configuration and address
  a_cfg_range: assert property (o_cfg inside {[CFG_MIN:CFG_MAX]})
    else $error("configuration out of range");
  a_cfg_switch_time: assert property ($rose(o_cfg_busy) |-> ##[1:260] !o_cfg_busy)
    else $error("configuration switch too slow");
  a_addr_range: assert property (o_dev_addr inside {[ADDR_MIN:ADDR_MAX]})
    else $error("own address out of range");
endmodule

/* tb/hlf_host_model.sv */
module hlf_host_model (
  // clock and line polarity
  input wire logic i_clk,
  input wire logic i_inv,
  // lines
  input wire logic i_line,
  output logic     o_rx,
  output logic     o_sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // host drives its transmit line at all times, mark when idle
  logic mark = 1'b1;
  assign o_rx = mark ^ i_inv;
  // bus master data line, released high outside its own writes
  logic dat = 1'b1;
  assign o_sda = dat;

  // bus write: start, address with write bit, five bytes, stop; q is a quarter bit
  task automatic i2c_wr(input logic [6:0] a, input logic [39:0] d, input int q, output int nak);
    logic [7:0] v;
    nak = 0;
    dat = 1'b0;
    repeat (q) @(negedge i_clk);
    mark = 1'b0;
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? {a, 1'b0} : d[8*(5-k) +: 8];
      for (int i = 8; i >= 0; i--) begin
        repeat (q) @(negedge i_clk);
        dat = (i == 0) ? 1'b1 : v[i-1];
        repeat (q) @(negedge i_clk);
        mark = 1'b1;
        repeat (q) @(negedge i_clk);
        if (i == 0 && i_line !== 1'b0) nak++;
        repeat (q) @(negedge i_clk);
        mark = 1'b0;
      end
    end
    repeat (q) @(negedge i_clk);
    dat = 1'b0;
    repeat (q) @(negedge i_clk);
    mark = 1'b1;
    repeat (q) @(negedge i_clk);
    dat = 1'b1;
  endtask

  // no flow control: characters leave back to back, no pause asked
  task automatic send(input logic [7:0] b, input int bits);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge i_clk);
      mark = f[i];
      repeat (bits - 1) @(negedge i_clk);
    end
  endtask

  task automatic recv(input int bits, output logic [7:0] b, output logic stop);
    int n;
    n = 0;
    while ((i_line ^ i_inv) !== 1'b0 && n < 40 * bits) begin
      @(negedge i_clk);
      n++;
    end
    repeat (bits / 2) @(negedge i_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bits) @(negedge i_clk);
      b[i] = i_line ^ i_inv;
    end
    repeat (bits) @(negedge i_clk);
    stop = i_line ^ i_inv;
  endtask
endmodule

/* tb/hlf_host_link_frontend_tb_top.sv */
`define CHK(name, exp, got) \
  begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", name, exp, got); end end

module hlf_host_link_frontend_tb_top
  import hlf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       clk = 1'b0;
  logic       rstn, clr, sel_a, sel_b, inv, rx, sda_wire, m_sda;
  logic       baud_load, addr_load, cfg_req, tx_valid;
  logic [1:0] baud_code;
  logic [7:0] addr, tx_data, o_cmd_code, o_param_data, o_dev_addr, cmd_code, param;
  logic [2:0] cfg_num, o_link, o_cfg;
  logic [1:0] o_baud_code;
  logic       o_sda_tx, o_sda_oe, o_tx_ready, o_link_valid, o_cfg_busy;
  logic       o_cmd_start, o_param_valid, o_cmd_done;
  int         error_cnt = 0;
  int         n_compared = 0;
  int         n_start, n_param, n_done;

  always #2.5 clk = ~clk;
  // pull-up on the shared data line; the host's bus master may pull it low as well
  assign sda_wire = (o_sda_oe ? o_sda_tx : 1'b1) & m_sda;

  hlf_host_link_frontend #(.DIV4800(64), .DIV9600(32), .DIV19200(16), .I2C_ADDR(7'h2a)) dut (
    .i_clk(clk), .i_rstn(rstn), .i_external_clear_pin(clr),
    .i_link_select_a(sel_a), .i_link_select_b(sel_b),
    .i_scl_rx(rx), .i_sda_tx(sda_wire), .o_sda_tx(o_sda_tx), .o_sda_oe(o_sda_oe),
    .i_baud_load(baud_load), .i_baud_code(baud_code), .i_addr_load(addr_load), .i_addr(addr),
    .i_cfg_req(cfg_req), .i_cfg_num(cfg_num),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(o_tx_ready),
    .o_link(o_link), .o_link_valid(o_link_valid), .o_baud_code(o_baud_code),
    .o_dev_addr(o_dev_addr), .o_cfg(o_cfg), .o_cfg_busy(o_cfg_busy),
    .o_cmd_start(o_cmd_start), .o_cmd_code(o_cmd_code), .o_param_valid(o_param_valid),
    .o_param_data(o_param_data), .o_cmd_done(o_cmd_done));

  hlf_host_model hm (.i_clk(clk), .i_inv(inv), .i_line(sda_wire), .o_rx(rx), .o_sda(m_sda));

  always @(negedge clk) begin
    if (o_cmd_start === 1'b1) begin n_start++; cmd_code = o_cmd_code; end
    if (o_param_valid === 1'b1) begin n_param++; param = o_param_data; end
    if (o_cmd_done === 1'b1) n_done++;
  end

  // ==========================================
  // helpers
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wait_valid();
    int n = 0;
    while (o_link_valid !== 1'b1 && n < 50) begin @(negedge clk); n++; end
    `CHK("link valid", 1'b1, o_link_valid)
  endtask

  task automatic do_reset(input logic a, input logic b);
    @(negedge clk); rstn = 0; sel_a = a; sel_b = b;
    repeat (5) @(negedge clk);
    rstn = 1;
    wait_valid();
  endtask

  // k: 0 rate, 1 address, 2 configuration
  task automatic load(input int k, input logic [7:0] v);
    @(negedge clk);
    baud_code = v[1:0]; addr = v; cfg_num = v[2:0];
    baud_load = (k == 0); addr_load = (k == 1); cfg_req = (k == 2);
    @(negedge clk);
    {baud_load, addr_load, cfg_req} = '0;
    repeat (3) @(negedge clk);
  endtask

  task automatic tx_byte(input logic [7:0] d);
    int n = 0;
    @(negedge clk); tx_valid = 1; tx_data = d;
    // ready seen at a falling edge stands until the rising edge that takes the byte
    while (o_tx_ready !== 1'b1 && n < 200) begin @(negedge clk); n++; end
    @(negedge clk); tx_valid = 0;
  endtask

  // ==========================================
  // scenarios
  task automatic t_straps();
    logic [1:0] sel[3] = '{2'b11, 2'b01, 2'b10}; // open strap reads high
    logic [2:0] exp[3] = '{LINK_I2C, LINK_SER, LINK_INV};
    foreach (sel[i]) begin
      inv = (i == 2);
      do_reset(sel[i][1], sel[i][0]);
      `CHK("link", exp[i], o_link)
      `CHK("pin drive", i != 0, o_sda_oe)
      @(negedge clk); sel_a = ~sel_a; sel_b = ~sel_b;
      repeat (10) @(negedge clk);
      `CHK("link held", exp[i], o_link)
    end
  endtask

  // second command goes to another address and must be ignored
  task automatic t_rx();
    string s = "/AX1\015/BY\015";
    n_start = 0; n_param = 0; n_done = 0;
    for (int i = 0; i < s.len(); i++) hm.send(s[i], 32);
    repeat (100) @(negedge clk);
    `CHK("cmd starts", 1, n_start)
    `CHK("cmd code", 8'h58, cmd_code)
    `CHK("params", 1, n_param)
    `CHK("param", 8'h31, param)
    `CHK("cmd done", 1, n_done)
  endtask

  // second write goes to a foreign bus address: nothing may be acked
  task automatic t_i2c();
    int nak;
    do_reset(1'b1, 1'b1);
    n_start = 0; n_param = 0; n_done = 0;
    hm.i2c_wr(7'h2a, 40'h2f415a370d, 8, nak);
    `CHK("i2c acks", 0, nak)
    `CHK("i2c code", 8'h5a, cmd_code)
    `CHK("i2c param", 8'h37, param)
    `CHK("i2c done", 1, n_done)
    hm.i2c_wr(7'h2b, 40'h2f415a370d, 8, nak);
    `CHK("i2c foreign", 6, nak)
  endtask

  task automatic t_tx(input int bits, input logic [7:0] d);
    logic [7:0] got;
    logic       stp;
    fork
      tx_byte(d);
      hm.recv(bits, got, stp);
    join
    `CHK("tx byte", d, got)
    `CHK("tx stop", 1'b1, stp)
  endtask

  task automatic t_baud();
    logic [1:0] codes[3] = '{BAUD_CODE_4800, BAUD_CODE_19200, BAUD_CODE_9600};
    int         bits[3] = '{64, 16, 32};
    foreach (codes[i]) begin
      load(0, {6'h2c, codes[i]});
      `CHK("baud", codes[i], o_baud_code)
      t_tx(bits[i], {6'h2c, codes[i]});
    end
    load(0, 8'h03);
    `CHK("baud kept", BAUD_CODE_9600, o_baud_code)
  endtask

  // a request during busy and an out-of-range number are both dropped
  task automatic t_cfg();
    int n = 0;
    load(2, 8'h02);
    `CHK("cfg busy", 1'b1, o_cfg_busy)
    load(2, 8'h03);
    while (o_cfg_busy !== 1'b0 && n < 400) begin @(negedge clk); n++; end
    `CHK("cfg", 3'h2, o_cfg)
    load(2, 8'h07);
    repeat (250) @(negedge clk);
    `CHK("cfg kept", 3'h2, o_cfg)
  endtask

  task automatic t_addr();
    load(1, ADDR_MAX);
    `CHK("addr", ADDR_MAX, o_dev_addr)
    load(1, 8'h5b);
    `CHK("addr above", ADDR_MAX, o_dev_addr)
    load(1, 8'h40);
    `CHK("addr below", ADDR_MAX, o_dev_addr)
    load(1, ADDR_RST);
  endtask

  task automatic t_clear();
    load(0, {6'h00, BAUD_CODE_19200});
    @(negedge clk); clr = 1; sel_a = 1; sel_b = 0;
    repeat (10) @(negedge clk);
    `CHK("valid in clear", 1'b0, o_link_valid)
    `CHK("baud in clear", BAUD_RST, o_baud_code)
    clr = 0; inv = 1;
    wait_valid();
    `CHK("relatched link", LINK_INV, o_link)
    `CHK("cfg kept", 3'h2, o_cfg)
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    rstn = 0; clr = 0; sel_a = 1; sel_b = 1; inv = 0;
    baud_load = 0; baud_code = 0; addr_load = 0; addr = 0;
    cfg_req = 0; cfg_num = 0; tx_valid = 0; tx_data = 0;
    t_straps();
    t_rx();
    t_tx(32, 8'h3c);
    inv = 0;
    t_i2c();
    do_reset(1'b0, 1'b1);
    t_rx();
    t_baud();
    t_cfg();
    t_addr();
    t_clear();
    t_rx();
    stop_test();
  end

  // whole sequence needs well under 60k cycles
  initial begin
    #400_000;
    error_cnt++;
    stop_test();
  end
endmodule

bind hlf_host_link_frontend hlf_chk u_chk (
  .i_clk, .i_rstn, .i_external_clear_pin, .o_sda_tx, .o_sda_oe, .o_tx_ready,
  .o_link, .o_link_valid, .o_baud_code, .o_dev_addr, .o_cfg, .o_cfg_busy);
